/* File: src/interval_defs.svh */
// Register map, field layout, reset values and rates for the interval
// counters. Included by bare name; holds definitions only.
`ifndef INTERVAL_DEFS_SVH
`define INTERVAL_DEFS_SVH

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004

// Control register fields
`define CTRL_RUN 0
`define CTRL_TACH_FALL 1
`define CTRL_PERIOD_ZERO 2
`define CTRL_STALE_EN 3
`define CTRL_PH_START_LO 4
`define CTRL_PH_STOP_LO 6
`define CTRL_PH_ZERO 8
`define CTRL_GT_START_LO 9
`define CTRL_GT_STOP_LO 11
`define CTRL_GT_ZERO 13
`define CTRL_MASK 32'h0000_3FFF
`define CTRL_RESET 32'h0000_334C

// Status register fields
`define STAT_PERIOD_LO 0
`define STAT_PHASE_LO 2
`define STAT_GATE_LO 4
`define STAT_TACH_LVL 6
`define STAT_GATE_LVL 7

// Channel list numbers of the three counters
`define CHAN_PERIOD 4
`define CHAN_PHASE 5
`define CHAN_GATE 6

// Clock rates in kHz
`define PCLK_KHZ 20000
`define PERIOD_REF_KHZ 12000
`define FAST_REF_KHZ 48000

// Width of a delivered result
`define RESULT_W 32

`endif

/* File: src/interval_pkg.sv */
// Types shared by the interval counter design files.
// Assumes nothing of its surroundings.
package interval_pkg;

   // Measurement state of one counter
   typedef enum logic [1:0] {
      CTR_ARMED,
      CTR_COUNTING,
      CTR_DONE
   } ctr_state_t;

   // Event selection for start and stop of a measurement
   typedef enum logic [1:0] {
      SEL_SAMPLE,
      SEL_RISE,
      SEL_FALL,
      SEL_NONE
   } evt_sel_t;

endpackage

/* File: src/edge_sync.sv */
// Two-stage synchroniser and edge detector, one lane per input bit.
// Assumes asynchronous inputs and one clock.
`timescale 1ns/100ps
`default_nettype none

module edge_sync
   import interval_pkg::*;
#(
   parameter int WIDTH = 2
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);

   initial
   begin
      if (WIDTH < 1) $error("edge_sync: WIDTH must be at least 1");
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_lane
         logic meta_reg;
         logic sync_reg;
         logic prev_reg;

         // Two flops, then a history flop for edge detection
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
               prev_reg <= 1'b0;
            end
            else
            begin
               meta_reg <= din[i];
               sync_reg <= meta_reg;
               prev_reg <= sync_reg;
            end
         end

         // One pulse per physical edge
         assign level[i] = prev_reg;
         assign rise[i] = sync_reg & ~prev_reg;
         assign fall[i] = ~sync_reg & prev_reg;
      end
   endgenerate

endmodule // edge_sync

`default_nettype wire

/* File: src/ref_tick_gen.sv */
// Fractional reference generator: tells how many reference clock periods
// elapse in each system clock period. Assumes REF and CLK in kHz.
`timescale 1ns/100ps
`default_nettype none

`include "interval_defs.svh"

module ref_tick_gen
   import interval_pkg::*;
#(
   parameter int CLK_KHZ = `PCLK_KHZ,
   parameter int REF_KHZ = `PERIOD_REF_KHZ,
   parameter int STEP_W = 2
)
(
   input wire logic clk,
   input wire logic rst_n,
   output logic [STEP_W-1:0] step
);

   localparam int ACC_W = $clog2(CLK_KHZ) + 1;
   localparam int SUM_W = $clog2(CLK_KHZ + REF_KHZ) + 1;
   localparam int MAX_STEP = (REF_KHZ + CLK_KHZ - 1) / CLK_KHZ;

   initial
   begin
      if (CLK_KHZ < 1 || REF_KHZ < 1)
         $error("ref_tick_gen: rates must be positive");
      if (MAX_STEP >= (1 << STEP_W))
         $error("ref_tick_gen: STEP_W too narrow for rate ratio");
   end

   logic [ACC_W-1:0] acc_reg;
   logic [STEP_W-1:0] step_reg;
   logic [SUM_W-1:0] sum;
   logic [SUM_W-1:0] quot;

   // Phase sum and whole reference periods in it
   assign sum = SUM_W'(acc_reg) + SUM_W'(REF_KHZ);
   assign quot = sum / SUM_W'(CLK_KHZ);

   // Keep the remainder, publish the whole periods
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_reg <= '0;
         step_reg <= '0;
      end
      else
      begin
         acc_reg <= ACC_W'(sum - quot * SUM_W'(CLK_KHZ));
         step_reg <= STEP_W'(quot);
      end
   end

   assign step = step_reg;

endmodule // ref_tick_gen

`default_nettype wire

/* File: src/tacho_gate_interval_counters.sv */
// Period, phase and gate interval counters read as channel list entries,
// with an APB register slave for configuration and status.
// Assumes tach and gate are asynchronous pins, the sample strobe is a
// one-cycle pulse in the pclk domain, and the channel sequencer presents
// one list entry per pclk cycle in which chan_valid is high.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

`include "interval_defs.svh"

module tacho_gate_interval_counters
   import interval_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int CHAN_W = 4,
   parameter bit EDGE_SELECTABLE = 1'b1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tach_in,
   input wire logic gate_in,
   input wire logic sample_strobe,
   input wire logic chan_valid,
   input wire logic [CHAN_W-1:0] chan_num,
   output logic res_valid,
   output logic [CHAN_W-1:0] res_chan,
   output logic [`RESULT_W-1:0] res_data
);

   localparam int NCTR = 3;
   localparam int CNT_W = `RESULT_W - 1;
   localparam int STEP_W = 2;

   initial
   begin
      if (ADDR_W < 3)
         $error("tacho_gate_interval_counters: ADDR_W too small");
      if ((1 << CHAN_W) <= `CHAN_GATE)
         $error("tacho_gate_interval_counters: CHAN_W too small");
   end

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////////

   logic [31:0] ctrl_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic res_valid_reg;
   logic [CHAN_W-1:0] res_chan_reg;
   logic [`RESULT_W-1:0] res_data_reg;

   logic [1:0] pin_level;
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;
   logic [STEP_W-1:0] slow_step;
   logic [STEP_W-1:0] fast_step;

   logic run;
   logic stale_en;
   logic tach_fall_sel;
   evt_sel_t ph_start_sel;
   evt_sel_t ph_stop_sel;
   evt_sel_t gt_start_sel;
   evt_sel_t gt_stop_sel;

   logic [NCTR-1:0] start_evt;
   logic [NCTR-1:0] stop_evt;
   logic [NCTR-1:0] read_zero;
   logic [NCTR-1:0] read_hit;
   logic [STEP_W-1:0] ctr_step [NCTR];
   ctr_state_t ctr_state [NCTR];
   logic [`RESULT_W-1:0] ctr_view [NCTR];

   logic setup_phase;
   logic access_wr;
   logic addr_ctrl;
   logic addr_status;
   logic [31:0] status_word;

   ////////////////////////////////////////////////////////////////////////
   // Input conditioning and reference rates
   ////////////////////////////////////////////////////////////////////////

   // Tachometer in lane 0, gate in lane 1
   edge_sync #(
      .WIDTH(2)
   ) u_edge_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din({gate_in, tach_in}),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Reference periods per pclk for the period counter
   ref_tick_gen #(
      .CLK_KHZ(`PCLK_KHZ),
      .REF_KHZ(`PERIOD_REF_KHZ),
      .STEP_W(STEP_W)
   ) u_slow_tick (
      .clk(pclk),
      .rst_n(presetn),
      .step(slow_step)
   );

   // Reference periods per pclk for the phase and gate counters
   ref_tick_gen #(
      .CLK_KHZ(`PCLK_KHZ),
      .REF_KHZ(`FAST_REF_KHZ),
      .STEP_W(STEP_W)
   ) u_fast_tick (
      .clk(pclk),
      .rst_n(presetn),
      .step(fast_step)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control field decode
   ////////////////////////////////////////////////////////////////////////

   // Configuration fields taken from the control register
   assign run = ctrl_reg[`CTRL_RUN];
   assign stale_en = ctrl_reg[`CTRL_STALE_EN];
   assign tach_fall_sel = EDGE_SELECTABLE & ctrl_reg[`CTRL_TACH_FALL];
   assign ph_start_sel = evt_sel_t'(ctrl_reg[`CTRL_PH_START_LO +: 2]);
   assign ph_stop_sel = evt_sel_t'(ctrl_reg[`CTRL_PH_STOP_LO +: 2]);
   assign gt_start_sel = evt_sel_t'(ctrl_reg[`CTRL_GT_START_LO +: 2]);
   assign gt_stop_sel = evt_sel_t'(ctrl_reg[`CTRL_GT_STOP_LO +: 2]);

   // Read-between-measurements choice per counter
   assign read_zero[0] = ctrl_reg[`CTRL_PERIOD_ZERO];
   assign read_zero[1] = ctrl_reg[`CTRL_PH_ZERO];
   assign read_zero[2] = ctrl_reg[`CTRL_GT_ZERO];

   // Count rate per counter
   assign ctr_step[0] = slow_step;
   assign ctr_step[1] = fast_step;
   assign ctr_step[2] = fast_step;

   ////////////////////////////////////////////////////////////////////////
   // Start and stop event selection
   ////////////////////////////////////////////////////////////////////////

   // Pick one event out of sample strobe and the two edges of a pin
   function automatic logic pick_evt(
      input evt_sel_t sel,
      input logic strobe,
      input logic rise_e,
      input logic fall_e
   );
      logic hit;
      hit = 1'b0;
      unique case (sel)
         SEL_SAMPLE: hit = strobe;
         SEL_RISE: hit = rise_e;
         SEL_FALL: hit = fall_e;
         SEL_NONE: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Period: start and stop on the same chosen tachometer edge
   always_comb
   begin
      start_evt[0] = tach_fall_sel ? pin_fall[0] : pin_rise[0];
      stop_evt[0] = start_evt[0];
   end

   // Phase: independent selection on tachometer edges
   always_comb
   begin
      start_evt[1] = pick_evt(ph_start_sel, sample_strobe, pin_rise[0],
                              pin_fall[0]);
      stop_evt[1] = pick_evt(ph_stop_sel, sample_strobe, pin_rise[0],
                             pin_fall[0]);
   end

   // Gate: independent selection on gate edges
   always_comb
   begin
      start_evt[2] = pick_evt(gt_start_sel, sample_strobe, pin_rise[1],
                              pin_fall[1]);
      stop_evt[2] = pick_evt(gt_stop_sel, sample_strobe, pin_rise[1],
                             pin_fall[1]);
   end

   // A channel list entry naming a counter reads it
   assign read_hit[0] = chan_valid && chan_num == CHAN_W'(`CHAN_PERIOD);
   assign read_hit[1] = chan_valid && chan_num == CHAN_W'(`CHAN_PHASE);
   assign read_hit[2] = chan_valid && chan_num == CHAN_W'(`CHAN_GATE);

   ////////////////////////////////////////////////////////////////////////
   // The three interval counters
   ////////////////////////////////////////////////////////////////////////

   genvar i;
   generate
      for (i = 0; i < NCTR; i++)
      begin : g_ctr
         ctr_state_t state_reg;
         logic [CNT_W-1:0] cnt_reg;
         logic [CNT_W-1:0] last_reg;
         logic [CNT_W:0] cnt_sum;
         logic [CNT_W-1:0] cnt_next;

         // Saturating count advance by the reference step
         assign cnt_sum = {1'b0, cnt_reg} + (CNT_W + 1)'(ctr_step[i]);
         assign cnt_next = cnt_sum[CNT_W] ? '1 : cnt_sum[CNT_W-1:0];

         // Measurement sequence: armed, counting, done until read
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               state_reg <= CTR_ARMED;
            else if (!run)
               state_reg <= CTR_ARMED;
            else
            begin
               unique case (state_reg)
                  CTR_ARMED:
                     if (start_evt[i])
                        state_reg <= CTR_COUNTING;
                  CTR_COUNTING:
                     if (stop_evt[i])
                        state_reg <= CTR_DONE;
                  CTR_DONE:
                     if (read_hit[i])
                        state_reg <= CTR_ARMED;
               endcase
            end
         end

         // Running count; stays frozen while done
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               cnt_reg <= '0;
            else if (state_reg == CTR_ARMED)
               cnt_reg <= '0;
            else if (state_reg == CTR_COUNTING && !stop_evt[i])
               cnt_reg <= cnt_next;
         end

         // Completed result kept for reads between measurements
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               last_reg <= '0;
            else if (run && state_reg == CTR_COUNTING && stop_evt[i])
               last_reg <= cnt_reg;
         end

         // Value a read returns: fresh result or the in-between value
         always_comb
         begin
            if (state_reg == CTR_DONE)
               ctr_view[i] = {1'b0, cnt_reg};
            else if (read_zero[i])
               ctr_view[i] = {stale_en, {CNT_W{1'b0}}};
            else
               ctr_view[i] = {stale_en, last_reg};
         end

         assign ctr_state[i] = state_reg;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Channel stream answer
   ////////////////////////////////////////////////////////////////////////

   // One registered answer per counter entry of the channel list
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         res_valid_reg <= 1'b0;
         res_chan_reg <= '0;
         res_data_reg <= '0;
      end
      else
      begin
         res_valid_reg <= |read_hit;
         res_chan_reg <= chan_num;
         if (read_hit[0])
            res_data_reg <= ctr_view[0];
         else if (read_hit[1])
            res_data_reg <= ctr_view[1];
         else if (read_hit[2])
            res_data_reg <= ctr_view[2];
      end
   end

   assign res_valid = res_valid_reg;
   assign res_chan = res_chan_reg;
   assign res_data = res_data_reg;

   ////////////////////////////////////////////////////////////////////////
   // APB slave
   ////////////////////////////////////////////////////////////////////////

   // Transfer phases and address decode
   assign setup_phase = psel && !penable;
   assign access_wr = psel && penable && pwrite;
   assign addr_ctrl = paddr == ADDR_W'(`OFS_CTRL);
   assign addr_status = paddr == ADDR_W'(`OFS_STATUS);

   // Status word: counter states and synchronised pin levels
   always_comb
   begin
      status_word = '0;
      status_word[`STAT_PERIOD_LO +: 2] = ctr_state[0];
      status_word[`STAT_PHASE_LO +: 2] = ctr_state[1];
      status_word[`STAT_GATE_LO +: 2] = ctr_state[2];
      status_word[`STAT_TACH_LVL] = pin_level[0];
      status_word[`STAT_GATE_LVL] = pin_level[1];
   end

   // Control register write in the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_reg <= `CTRL_RESET;
      else if (access_wr && addr_ctrl)
         ctrl_reg <= pwdata & `CTRL_MASK;
   end

   // Read data and error prepared in the setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
      end
      else if (setup_phase)
      begin
         pslverr_reg <= !(addr_ctrl || addr_status);
         if (pwrite)
            prdata_reg <= '0;
         else if (addr_ctrl)
            prdata_reg <= ctrl_reg;
         else if (addr_status)
            prdata_reg <= status_word;
         else
            prdata_reg <= '0;
      end
   end

   // Zero-wait answer; data and error only shown while ready
   assign pready = psel && penable;
   assign prdata = pready ? prdata_reg : '0;
   assign pslverr = pready && pslverr_reg;

endmodule // tacho_gate_interval_counters

`default_nettype wire

/* File: tb/interval_checker.sv */
// Checker for the interval counters: channel answers and result format.
// Sees only the top module's ports; attached by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
`include "interval_defs.svh"

module interval_checker
#(
   parameter int ADDR_W = 12,
   parameter int CHAN_W = 4
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tach_in,
   input wire logic gate_in,
   input wire logic sample_strobe,
   input wire logic chan_valid,
   input wire logic [CHAN_W-1:0] chan_num,
   input wire logic res_valid,
   input wire logic [CHAN_W-1:0] res_chan,
   input wire logic [`RESULT_W-1:0] res_data
);
   logic [31:0] ctrl_shadow;
   logic ctr_chan;
   logic fresh_period;

   // Copy of the control word, taken from completed writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_shadow <= `CTRL_RESET;
      else if (psel && penable && pready && pwrite && paddr == `OFS_CTRL)
         ctrl_shadow <= pwdata & `CTRL_MASK;
   end

   // Entry aimed at a counter, and a new period result
   assign ctr_chan = chan_valid && chan_num >= `CHAN_PERIOD
      && chan_num <= `CHAN_GATE;
   assign fresh_period = res_valid && res_chan == `CHAN_PERIOD
      && !res_data[31] && ctrl_shadow[`CTRL_STALE_EN];

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////
   property p_answer;
      ctr_chan |=> res_valid && res_chan == $past(chan_num);
   endproperty
   a_answer: assert property (p_answer)
      else $error("counter entry not answered next cycle");
   property p_silent;
      chan_valid && !ctr_chan |=> !res_valid;
   endproperty
   a_silent: assert property (p_silent)
      else $error("answer for a non-counter entry");
   property p_cause;
      res_valid |-> $past(ctr_chan);
   endproperty
   a_cause: assert property (p_cause)
      else $error("answer without a counter entry");
   property p_hold;
      !res_valid |-> $stable(res_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("result moved without an answer");
   property p_stale_off;
      res_valid && !ctrl_shadow[`CTRL_STALE_EN] |-> !res_data[31];
   endproperty
   a_stale_off: assert property (p_stale_off)
      else $error("top bit set with flag disabled");
   property p_zero_between;
      res_valid && res_chan == `CHAN_PERIOD && res_data[31]
         && ctrl_shadow[`CTRL_PERIOD_ZERO] |-> res_data[30:0] == 0;
   endproperty
   a_zero_between: assert property (p_zero_between)
      else $error("period read between results not zero");
   property p_self_clear;
      res_valid && res_chan != `CHAN_PERIOD && res_data[31]
         && ctrl_shadow[`CTRL_PH_ZERO] && ctrl_shadow[`CTRL_GT_ZERO]
         |-> res_data[30:0] == 0;
   endproperty
   a_self_clear: assert property (p_self_clear)
      else $error("self-clear read not zero");
   property p_idle_done;
      fresh_period |=> !fresh_period [*2];
   endproperty
   a_idle_done: assert property (p_idle_done)
      else $error("new period result without a measurement");

   c_fresh: cover property (fresh_period);
   c_gate: cover property (res_valid && res_chan == `CHAN_GATE);
   c_back: cover property (ctr_chan ##1 ctr_chan);
endmodule // interval_checker

bind tacho_gate_interval_counters interval_checker
   #(.ADDR_W(ADDR_W), .CHAN_W(CHAN_W)) chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .tach_in(tach_in), .gate_in(gate_in),
   .sample_strobe(sample_strobe), .chan_valid(chan_valid),
   .chan_num(chan_num), .res_valid(res_valid), .res_chan(res_chan),
   .res_data(res_data));
`default_nettype wire

/* File: tb/pin_source.sv */
// Far side: tachometer and gate pins and the sample strobe.
// Pins are asynchronous; the strobe is one pclk cycle wide.
`timescale 1ns/100ps
`default_nettype none

module pin_source
   import interval_pkg::*;
(
   input wire logic pclk,
   output var logic tach_in,
   output var logic gate_in,
   output var logic sample_strobe
);
   int tach_half = 0;

   initial
   begin
      tach_in = 1'b0;
      gate_in = 1'b0;
      sample_strobe = 1'b0;
   end

   // Free-running tachometer; stands at its level while half is zero
   always
   begin
      if (tach_half == 0)
         #10;
      else
      begin
         #(tach_half);
         if (tach_half != 0)
            tach_in = ~tach_in;
      end
   end

   // One event; t is the moment the counter should see it
   task automatic ev(input evt_sel_t sel, input bit on_gate,
      output realtime t);
      logic want;
      want = (sel == SEL_RISE);
      if (sel == SEL_SAMPLE)
      begin
         @(posedge pclk);
         sample_strobe <= 1'b1;
         @(posedge pclk);
         t = $realtime;
         sample_strobe <= 1'b0;
      end
      else
      begin
         if ((on_gate ? gate_in : tach_in) == want)
         begin
            if (on_gate) gate_in = ~want;
            else tach_in = ~want;
            #200;
         end
         if (on_gate) gate_in = want;
         else tach_in = want;
         t = $realtime + 125; // Two to three cycles of synchroniser
      end
   endtask
endmodule // pin_source
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench for the interval counters: APB setup, pins, channel reads.
// Assumes zero-wait APB and answers one cycle after each entry.
`timescale 1ns/100ps
`default_nettype none
`include "interval_defs.svh"

module tb_top
   import interval_pkg::*;
();
   typedef struct {logic [3:0] ch; logic [31:0] d; int tol;} note_t;
   logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, res_data, seed;
   logic tach_in, gate_in, sample_strobe, chan_valid, res_valid;
   logic [3:0] chan_num, res_chan;
   note_t notes[$];
   int miscompares = 0;
   int checked = 0;

   tacho_gate_interval_counters #(.ADDR_W(12), .CHAN_W(4)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tach_in(tach_in),
      .gate_in(gate_in), .sample_strobe(sample_strobe),
      .chan_valid(chan_valid), .chan_num(chan_num), .res_valid(res_valid),
      .res_chan(res_chan), .res_data(res_data));
   pin_source far (.pclk(pclk), .tach_in(tach_in), .gate_in(gate_in),
      .sample_strobe(sample_strobe));

   ////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input int tol);
      int diff;
      diff = int'(seen) - int'(exp);
      checked++;
      if (seen !== exp && ($isunknown(seen) || diff > tol || diff < -tol))
      begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // One APB transfer, held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      check(q, exp, 0);
      check({31'h0, e}, {31'h0, err}, 0);
   endtask

   task wait_done(input int lo);
      logic [31:0] q;
      logic e;
      q = 32'h0;
      for (int i = 0; i < 2000 && q[lo+:2] !== 2'h2; i++)
         apb(1'b0, `OFS_STATUS, 32'h0, q, e);
      check({30'h0, q[lo+:2]}, 32'h2, 0);
   endtask

   // One list entry; a negative tolerance means no answer is due
   task chan_rd(input logic [3:0] ch, input logic [31:0] exp, input int tol);
      @(posedge pclk);
      chan_valid <= 1'b1;
      chan_num <= ch;
      if (tol >= 0) notes.push_back('{ch, exp, tol});
   endtask

   task chan_idle;
      @(posedge pclk);
      chan_valid <= 1'b0;
   endtask

   ////////////////////////////////////////
   // Answers compared against the oldest note
   always @(posedge pclk)
   begin
      note_t n;
      if (res_valid === 1'b1)
      begin
         n = '{4'hF, 32'h0, 0};
         if (notes.size() > 0) n = notes.pop_front();
         check({28'h0, res_chan}, {28'h0, n.ch}, 0);
         check(res_data, n.d, n.tol);
      end
   end

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Watchdog well beyond the expected run of under 2k cycles
   initial
   begin
      #4_000_000;
      miscompares++;
      end_sim;
   end

   initial
   begin
      logic [31:0] q, v;
      logic e, g;
      realtime t0, t1;
      int h, cnt, d;
      logic [2:0] tcfg [4] = '{3'h6, 3'h0, 3'h7, 3'h4};
      logic [3:0] tch [8] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h6, 4'h6, 4'h6, 4'h6};
      evt_sel_t st [8] = '{SEL_SAMPLE, SEL_SAMPLE, SEL_RISE, SEL_FALL,
         SEL_SAMPLE, SEL_RISE, SEL_RISE, SEL_FALL};
      evt_sel_t sp [8] = '{SEL_RISE, SEL_FALL, SEL_SAMPLE, SEL_SAMPLE,
         SEL_FALL, SEL_FALL, SEL_RISE, SEL_SAMPLE};
      {presetn, psel, penable, pwrite, chan_valid} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      chan_num = 4'h0;
      seed = 32'h00BA;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`OFS_CTRL, `CTRL_RESET, 1'b0);
      rd_chk(`OFS_STATUS, 32'h0, 1'b0);
      rd_chk(12'h008, 32'h0, 1'b1);
      apb(1'b1, `OFS_CTRL, 32'hFFFF_FFFF, q, e);
      rd_chk(`OFS_CTRL, `CTRL_MASK, 1'b0);
      apb(1'b1, `OFS_CTRL, `CTRL_RESET, q, e);
      // Idle counters: stale zero, back to back, others silent
      for (int i = 0; i < 16; i++)
      begin
         seed = xs(seed);
         v = (i < 8) ? i + 2 : seed[3:0];
         chan_rd(v[3:0], 32'h8000_0000, (v >= 4 && v <= 6) ? 0 : -1);
      end
      chan_idle;
      // Period in three read modes, on both tachometer edges
      seed = xs(seed);
      h = 600 + seed[9:0] % 700;
      cnt = 2 * h * 12 / 1000;
      far.tach_half = h;
      for (int k = 0; k < 4; k++)
      begin
         v = (`CTRL_RESET & 32'hFFFF_FFF0) | {28'h0, tcfg[k], 1'b0};
         apb(1'b1, `OFS_CTRL, v, q, e);
         apb(1'b1, `OFS_CTRL, v | 32'h1, q, e);
         wait_done(`STAT_PERIOD_LO);
         repeat (200) @(posedge pclk);
         chan_rd(4'h4, cnt, 2);
         chan_rd(4'h4, {tcfg[k][2], tcfg[k][1] ? 31'h0 : cnt[30:0]},
            tcfg[k][1] ? 0 : 2);
         chan_idle;
      end
      far.tach_half = 0;
      // Phase and gate intervals over sample, rising and falling event selections
      for (int k = 0; k < 8; k++)
      begin
         g = (tch[k] == 4'h6);
         v = g ? ((`CTRL_RESET & ~32'h1E00) | (st[k] << `CTRL_GT_START_LO)
            | (sp[k] << `CTRL_GT_STOP_LO)) : ((`CTRL_RESET & ~32'hF0)
            | (st[k] << `CTRL_PH_START_LO) | (sp[k] << `CTRL_PH_STOP_LO));
         apb(1'b1, `OFS_CTRL, `CTRL_RESET, q, e);
         apb(1'b1, `OFS_CTRL, v | 32'h1, q, e);
         seed = xs(seed);
         d = 500 + seed[9:0];
         far.ev(st[k], g, t0);
         #(d);
         far.ev(sp[k], g, t1);
         wait_done(g ? `STAT_GATE_LO : `STAT_PHASE_LO);
         chan_rd(tch[k], int'((t1 - t0 - 50) * 48.0 / 1000.0), 5);
         chan_rd(tch[k], 32'h8000_0000, 0);
         chan_idle;
      end
      repeat (3) @(posedge pclk);
      check(notes.size(), 0, 0);
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
